// ==== common/hb_pkg.sv ====
package hb_pkg;

  // clock: 250 MHz
  localparam int CLK_PERIOD_PS = 4000;

  // interval lengths are free choices; counts round up to whole cycles
  localparam int DEAD_NS = 100;
  localparam int STEP_BLANK_NS = 1000;
  localparam int DC_BLANK_NS = 4000;
  localparam int DEAD_CYCLES =
    (DEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STEP_BLANK_CYCLES =
    (STEP_BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DC_BLANK_CYCLES =
    (DC_BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam int NUM_BRIDGES = 4;

  // register byte offsets
  localparam logic [4:0] ADDR_SETUP = 5'h00;
  localparam logic [4:0] ADDR_STEP_AB = 5'h04;
  localparam logic [4:0] ADDR_STEP_CD = 5'h08;
  localparam logic [4:0] ADDR_SENSE_REF = 5'h0C;
  localparam logic [4:0] ADDR_STATUS = 5'h10;

  // field positions
  localparam int CFG_LSB = 0;
  localparam int CUR_FIRST_LSB = 11;
  localparam int CUR_SECOND_LSB = 4;
  localparam int REF_FIRST_LSB = 0;
  localparam int REF_SECOND_LSB = 4;
  localparam int STAT_SW_LSB = 0;
  localparam int STAT_CHOP_LSB = 16;
  localparam int STAT_REMAP_BIT = 20;
  localparam int STAT_SLEEP_BIT = 21;
  localparam int STAT_OCP_BIT = 22;
  localparam int STAT_TSD_BIT = 23;

  // reset values
  localparam logic [2:0] SETUP_RST = 3'h0;
  localparam logic [3:0] CUR_RST = 4'h0;
  localparam logic [3:0] REF_RST = 4'hF;

  typedef enum logic [2:0] {
    HB_CFG_TWO_STEPPER = 3'h0,
    HB_CFG_STEP_LARGE_DC = 3'h1,
    HB_CFG_STEP_TWO_DC = 3'h2,
    HB_CFG_LARGE_TWO_DC = 3'h3,
    HB_CFG_TWO_LARGE_DC = 3'h4,
    HB_CFG_FOUR_DC = 3'h5,
    HB_CFG_LARGE_STEPPER = 3'h6,
    HB_CFG_ULTRA_DC = 3'h7
  } hb_cfg_t;

  // one bridge's four switches
  typedef struct packed {
    logic plus_high;
    logic plus_low;
    logic minus_high;
    logic minus_low;
  } hb_switch_t;

  // one bridge's resolved command
  typedef struct packed {
    logic stepper;
    logic enable;
    logic direction;
  } hb_cmd_t;

endpackage

// ==== rtl/hb_dead_time.sv ====
`timescale 1ns/100ps
module hb_dead_time #(
  parameter int DEAD_CYC = hb_pkg::DEAD_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic req_high,
  input wire logic req_low,
  output logic high_on,
  output logic low_on
);
  import hb_pkg::*;

  localparam int CW = $clog2(DEAD_CYC + 1);

  typedef struct packed {
    logic hi;
    logic lo;
    logic [CW-1:0] cnt;
  } hb_dt_state_t;

  hb_dt_state_t s;
  hb_dt_state_t next_s;

  always_comb begin
    next_s = s;
    if (s.cnt != '0) begin
      next_s.cnt = s.cnt - 1'b1;
    end
    // both switches off, gap counted, before any switch turns on
    if ((s.hi && !req_high) || (s.lo && !req_low)) begin
      next_s.hi = 1'b0;
      next_s.lo = 1'b0;
      next_s.cnt = CW'(DEAD_CYC);
    end else if (!s.hi && !s.lo && s.cnt == '0) begin
      next_s.hi = req_high;
      next_s.lo = req_low && !req_high;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign high_on = s.hi;
  assign low_on = s.lo;
endmodule // hb_dead_time

// ==== rtl/hb_blank.sv ====
`timescale 1ns/100ps
module hb_blank #(
  parameter int STEP_CYC = hb_pkg::STEP_BLANK_CYCLES,
  parameter int DC_CYC = hb_pkg::DC_BLANK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic bridge_on,
  input wire logic stepper,
  input wire logic raw_trip,
  output logic trip
);
  import hb_pkg::*;

  localparam int MAXC = (STEP_CYC > DC_CYC) ? STEP_CYC : DC_CYC;
  localparam int CW = $clog2(MAXC + 1);

  typedef struct packed {
    logic on_d;
    logic [CW-1:0] cnt;
    logic trip;
  } hb_bl_state_t;

  hb_bl_state_t s;
  hb_bl_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.on_d = bridge_on;
    if (s.cnt != '0) begin
      next_s.cnt = s.cnt - 1'b1;
    end
    // window restarts at every turn-on; longer one hides dc rush current
    if (bridge_on && !s.on_d) begin
      next_s.cnt = stepper ? CW'(STEP_CYC) : CW'(DC_CYC);
    end
    next_s.trip = bridge_on && s.on_d && s.cnt == '0 && raw_trip;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign trip = s.trip;
endmodule // hb_blank

// ==== rtl/hb_motor_ctrl.sv ====
`timescale 1ns/100ps
// Operation
// - each side has a dead gap before its opposite switch turns on.
// - sense comparator ignored for a blanking window after bridge turn-on.
// - winding current picks one of sixteen levels from a four-bit code.
// - stepper word holds first winding code at 14:11, second at 7:4.
// - stepper bridges use only the stepper blanking window.
// - dc bridges use a separate longer blanking window.
// - dc grouping is single bridge, paired bridges, or all four.
// - config 5 drives each bridge from its own enable and direction.
// - config 5 pin remap takes effect only once sleep control is high.
// - config 3 pairs A with B on paired inputs; C, D independent.
// - A and B share one reference, C and D share another.
// - sleep or faults turn all switches off; disable or a latched chop turns off that bridge's switches; else direction map.
// - setup code selects one of eight motor arrangements.
module hb_motor_ctrl #(
  parameter int DEAD_CYC = hb_pkg::DEAD_CYCLES,
  parameter int STEP_BLANK_CYC = hb_pkg::STEP_BLANK_CYCLES,
  parameter int DC_BLANK_CYC = hb_pkg::DC_BLANK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic sleep_control_low,
  input wire logic [3:0] bridge_enable_x,
  input wire logic [3:0] bridge_direction_x,
  input wire logic paired_bridge_enable,
  input wire logic paired_bridge_direction,
  input wire logic overcurrent_fault,
  input wire logic thermal_shutdown_fault,
  input wire logic [3:0] sense_trip_raw,
  output hb_pkg::hb_switch_t [3:0] bridge_switch,
  output logic [15:0] winding_current_code,
  output logic [3:0] sense_reference_first_pair,
  output logic [3:0] sense_reference_second_pair
);
  import hb_pkg::*;

  typedef struct packed {
    hb_cfg_t cfg;
    logic [3:0] cur_a;
    logic [3:0] cur_b;
    logic [3:0] cur_c;
    logic [3:0] cur_d;
    logic [3:0] ref_ab;
    logic [3:0] ref_cd;
    logic dp_valid;
    logic dp_write;
    logic [4:0] dp_addr;
    logic rd_wait;
    logic [31:0] rdata;
    logic [3:0] chop;
    logic remap;
    logic [3:0] last_en;
    logic [3:0] last_dir;
    logic [15:0] cur_out;
  } hb_state_t;

  hb_state_t s;
  hb_state_t next_s;

  hb_cmd_t [3:0] cmd;
  logic [3:0] go;
  logic [3:0] trip;
  logic [3:0] group_trip;
  hb_switch_t [3:0] sw;

  // stepper bridges per arrangement
  function automatic logic is_stepper(input hb_cfg_t c, input int i);
    case (c)
      HB_CFG_TWO_STEPPER, HB_CFG_LARGE_STEPPER: is_stepper = 1'b1;
      HB_CFG_STEP_LARGE_DC, HB_CFG_STEP_TWO_DC: is_stepper = (i < 2);
      default: is_stepper = 1'b0;
    endcase
  endfunction

  // lowest bridge of the parallel group that bridge i belongs to
  function automatic int leader(input hb_cfg_t c, input int i);
    case (c)
      HB_CFG_ULTRA_DC: leader = 0;
      HB_CFG_LARGE_TWO_DC: leader = (i < 2) ? 0 : i;
      HB_CFG_TWO_LARGE_DC: leader = (i < 2) ? 0 : 2;
      HB_CFG_STEP_LARGE_DC: leader = (i < 2) ? i : 2;
      default: leader = i;
    endcase
  endfunction

  function automatic logic [31:0] read_mux(input hb_state_t st,
                                           input logic [4:0] a,
                                           input logic [31:0] stat);
    logic [31:0] r;
    r = '0;
    case (a)
      ADDR_SETUP: r[CFG_LSB +: 3] = st.cfg;
      ADDR_STEP_AB: begin
        r[CUR_FIRST_LSB +: 4] = st.cur_a;
        r[CUR_SECOND_LSB +: 4] = st.cur_b;
      end
      ADDR_STEP_CD: begin
        r[CUR_FIRST_LSB +: 4] = st.cur_c;
        r[CUR_SECOND_LSB +: 4] = st.cur_d;
      end
      ADDR_SENSE_REF: begin
        r[REF_FIRST_LSB +: 4] = st.ref_ab;
        r[REF_SECOND_LSB +: 4] = st.ref_cd;
      end
      ADDR_STATUS: r = stat;
      default: r = '0;
    endcase
    return r;
  endfunction

  logic [31:0] status;
  logic addr_phase;
  logic [3:0] code [4];

  always_comb begin
    status = '0;
    status[STAT_SW_LSB +: 16] = sw;
    status[STAT_CHOP_LSB +: 4] = s.chop;
    status[STAT_REMAP_BIT] = s.remap;
    status[STAT_SLEEP_BIT] = sleep_control_low;
    status[STAT_OCP_BIT] = overcurrent_fault;
    status[STAT_TSD_BIT] = thermal_shutdown_fault;
  end

  // large stepper runs C and D from the first word, in step with A and B
  always_comb begin
    code[0] = s.cur_a;
    code[1] = s.cur_b;
    if (s.cfg == HB_CFG_LARGE_STEPPER) begin
      code[2] = s.cur_a;
      code[3] = s.cur_b;
    end else begin
      code[2] = s.cur_c;
      code[3] = s.cur_d;
    end
  end

  // command resolution: every group member reads the leader's source
  always_comb begin
    for (int i = 0; i < NUM_BRIDGES; i++) begin
      int l;
      l = leader(s.cfg, i);
      cmd[i].stepper = is_stepper(s.cfg, i);
      if (cmd[i].stepper) begin
        cmd[i].enable = (code[i] != 4'h0);
        cmd[i].direction = bridge_direction_x[i];
      end else if (s.cfg == HB_CFG_ULTRA_DC || (l == 0 &&
                   (s.cfg == HB_CFG_LARGE_TWO_DC ||
                    s.cfg == HB_CFG_TWO_LARGE_DC))) begin
        cmd[i].enable = paired_bridge_enable;
        cmd[i].direction = paired_bridge_direction;
      end else begin
        cmd[i].enable = bridge_enable_x[l];
        cmd[i].direction = bridge_direction_x[l];
      end
      // shared pins carry bus framing until the remap has happened
      if (s.cfg == HB_CFG_FOUR_DC && !s.remap) begin
        cmd[i].enable = 1'b0;
      end
    end
  end

  // a trip anywhere in a group stops the whole group together
  always_comb begin
    for (int i = 0; i < NUM_BRIDGES; i++) begin
      group_trip[i] = 1'b0;
      for (int j = 0; j < NUM_BRIDGES; j++) begin
        if (leader(s.cfg, j) == leader(s.cfg, i)) begin
          group_trip[i] = group_trip[i] | trip[j];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_BRIDGES; i++) begin
      go[i] = sleep_control_low && cmd[i].enable && !s.chop[i] &&
              !overcurrent_fault && !thermal_shutdown_fault;
    end
  end

  for (genvar g = 0; g < NUM_BRIDGES; g++) begin : g_bridge
    // direction low: plus low, minus high; direction high: the reverse
    hb_dead_time #(.DEAD_CYC(DEAD_CYC)) u_plus (
      .hclk(hclk),
      .hresetn(hresetn),
      .req_high(go[g] && cmd[g].direction),
      .req_low(go[g] && !cmd[g].direction),
      .high_on(sw[g].plus_high),
      .low_on(sw[g].plus_low)
    );
    hb_dead_time #(.DEAD_CYC(DEAD_CYC)) u_minus (
      .hclk(hclk),
      .hresetn(hresetn),
      .req_high(go[g] && !cmd[g].direction),
      .req_low(go[g] && cmd[g].direction),
      .high_on(sw[g].minus_high),
      .low_on(sw[g].minus_low)
    );
    hb_blank #(
      .STEP_CYC(STEP_BLANK_CYC),
      .DC_CYC(DC_BLANK_CYC)
    ) u_blank (
      .hclk(hclk),
      .hresetn(hresetn),
      .bridge_on(sw[g].plus_high | sw[g].plus_low),
      .stepper(cmd[g].stepper),
      .raw_trip(sense_trip_raw[g]),
      .trip(trip[g])
    );
  end

  assign addr_phase = hsel && hready && htrans[1];

  always_comb begin
    next_s = s;
    // bus data phase
    if (s.dp_valid && s.dp_write) begin
      case (s.dp_addr)
        ADDR_SETUP: next_s.cfg = hb_cfg_t'(hwdata[CFG_LSB +: 3]);
        ADDR_STEP_AB: begin
          next_s.cur_a = hwdata[CUR_FIRST_LSB +: 4];
          next_s.cur_b = hwdata[CUR_SECOND_LSB +: 4];
        end
        ADDR_STEP_CD: begin
          next_s.cur_c = hwdata[CUR_FIRST_LSB +: 4];
          next_s.cur_d = hwdata[CUR_SECOND_LSB +: 4];
        end
        ADDR_SENSE_REF: begin
          next_s.ref_ab = hwdata[REF_FIRST_LSB +: 4];
          next_s.ref_cd = hwdata[REF_SECOND_LSB +: 4];
        end
        default: next_s.cfg = s.cfg;
      endcase
    end
    // reads spend one wait cycle so read data leaves a flip-flop
    if (s.dp_valid && !s.dp_write && s.rd_wait) begin
      next_s.rdata = read_mux(s, s.dp_addr, status);
      next_s.rd_wait = 1'b0;
    end else if (hreadyout) begin
      next_s.dp_valid = addr_phase;
      next_s.dp_write = hwrite;
      next_s.dp_addr = haddr[4:0] & {5{haddr[31:5] == '0}} |
                       {5{haddr[31:5] != '0}};
      next_s.rd_wait = addr_phase && !hwrite;
    end
    // remap latches while sleep control is high and holds until config leaves 5
    if (s.cfg != HB_CFG_FOUR_DC) begin
      next_s.remap = 1'b0;
    end else if (sleep_control_low) begin
      next_s.remap = 1'b1;
    end
    // chop latch: new command clears, a trip in the same cycle wins
    for (int i = 0; i < NUM_BRIDGES; i++) begin
      logic clr;
      clr = !cmd[i].enable || cmd[i].enable != s.last_en[i] ||
            cmd[i].direction != s.last_dir[i];
      next_s.chop[i] = group_trip[i] | (s.chop[i] & !clr);
      next_s.last_en[i] = cmd[i].enable;
      next_s.last_dir[i] = cmd[i].direction;
      next_s.cur_out[4*i +: 4] = cmd[i].stepper ? code[i] : 4'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.cfg <= hb_cfg_t'(SETUP_RST);
      s.cur_a <= CUR_RST;
      s.cur_b <= CUR_RST;
      s.cur_c <= CUR_RST;
      s.cur_d <= CUR_RST;
      s.ref_ab <= REF_RST;
      s.ref_cd <= REF_RST;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = !(s.dp_valid && !s.dp_write && s.rd_wait);
  assign hrdata = s.rdata;
  assign hresp = 1'b0;
  assign bridge_switch = sw;
  assign winding_current_code = s.cur_out;
  // comparator references shared per pair
  assign sense_reference_first_pair = s.ref_ab;
  assign sense_reference_second_pair = s.ref_cd;
endmodule // hb_motor_ctrl

// ==== test/hb_motor_ctrl_chk.sv ====
`timescale 1ns/100ps
module hb_motor_ctrl_chk #(
  parameter int DEAD_CYC = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic sleep_control_low,
  input wire logic overcurrent_fault,
  input wire logic thermal_shutdown_fault,
  input wire hb_pkg::hb_switch_t [3:0] bridge_switch
);
  import hb_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic req;
  logic shoot;
  logic [7:0] gap;
  assign req = hsel && hready && htrans[1];
  // saturating count of cycles since plus high was last on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap <= 8'hFF;
    end else if (bridge_switch[0].plus_high) begin
      gap <= 8'h00;
    end else if (gap != 8'hFF) begin
      gap <= gap + 8'h01;
    end
  end
  always_comb begin
    shoot = 1'b0;
    for (int i = 0; i < 4; i++) begin
      shoot |= bridge_switch[i].plus_high & bridge_switch[i].plus_low;
      shoot |= bridge_switch[i].minus_high & bridge_switch[i].minus_low;
    end
  end
  property p_dead;
    $rose(bridge_switch[0].plus_low) |-> gap >= DEAD_CYC + 1;
  endproperty
  a_dead: assert property (p_dead) else $error("dead gap too short");
  property p_no_shoot;
    !shoot;
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("side shoot");
  property p_sleep_off;
    !sleep_control_low |=> bridge_switch == '0;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("on in sleep");
  property p_fault_off;
    overcurrent_fault || thermal_shutdown_fault |=> bridge_switch == '0;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("on in fault");
  property p_wr_ok;
    req && hwrite |=> hreadyout;
  endproperty
  a_wr_ok: assert property (p_wr_ok) else $error("write stalled");
  property p_rd_wait;
    req && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_rd_hold;
    hreadyout && $past(hreadyout) |-> $stable(hrdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  cover property ($rose(bridge_switch[0].plus_low));
  cover property (req && !hwrite);
  cover property (overcurrent_fault ##1 bridge_switch == '0);
endmodule // hb_motor_ctrl_chk

// ==== test/hb_host.sv ====
`timescale 1ns/100ps
module hb_host (
  input wire logic [4:0] step_k,
  output logic [31:0] step_word
);
  import hb_pkg::*;
  always_comb begin
    step_word = 32'h00000000;
    step_word[CUR_FIRST_LSB +: 4] = (step_k > 5'h0F) ? 4'hF : step_k[3:0];
    step_word[CUR_SECOND_LSB +: 4] =
      (step_k == 5'h00) ? 4'hF : 4'(5'h10 - step_k);
  end
endmodule // hb_host

// ==== test/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import hb_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans, p;
  logic [2:0] hsize, c;
  logic [31:0] haddr, hwdata, hrdata, word, q, rnd;
  logic sleep_control_low, paired_bridge_enable, paired_bridge_direction;
  logic overcurrent_fault, thermal_shutdown_fault;
  logic [3:0] bridge_enable_x, bridge_direction_x, sense_trip_raw, e, d;
  logic [3:0] sense_reference_first_pair, sense_reference_second_pair;
  logic [15:0] winding_current_code, x;
  hb_switch_t [3:0] bridge_switch;
  logic [4:0] step_k;
  logic [2:0] cfgl [4] = '{3'h3, 3'h4, 3'h7, 3'h5};
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  assign hready = hreadyout;
  hb_motor_ctrl #(.DEAD_CYC(2), .STEP_BLANK_CYC(4), .DC_BLANK_CYC(8)) u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hrdata, .hresp, .sleep_control_low,
    .bridge_enable_x, .bridge_direction_x, .paired_bridge_enable,
    .paired_bridge_direction, .overcurrent_fault, .thermal_shutdown_fault,
    .sense_trip_raw, .bridge_switch, .winding_current_code,
    .sense_reference_first_pair, .sense_reference_second_pair);
  hb_host u_host (.step_k, .step_word(word));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected switch nibbles: dir low = plus low + minus high
  function automatic logic [15:0] exp4(input logic [3:0] en, dr);
    for (int i = 0; i < 4; i++) begin
      exp4[4*i +: 4] = en[i] ? (dr[i] ? 4'h9 : 4'h6) : 4'h0;
    end
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic pins(input logic s);
    sleep_control_low <= s;
    bridge_enable_x <= e;
    bridge_direction_x <= d;
    {paired_bridge_enable, paired_bridge_direction} <= p;
    repeat (10) @(posedge hclk);
  endtask
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, step_k} = '0;
    {e, d, p, overcurrent_fault, thermal_shutdown_fault} = '0;
    {sleep_control_low, bridge_enable_x, bridge_direction_x} = '0;
    {paired_bridge_enable, paired_bridge_direction, sense_trip_raw} = '0;
    hsize = 3'h2;
    rnd = 32'h00011844;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 32'(ADDR_SENSE_REF), 32'h0);
    chk(q[7:0], 8'hFF);
    rnd = lfsr(rnd);
    bus(1'b1, 32'(ADDR_SENSE_REF), rnd);
    bus(1'b0, 32'(ADDR_SENSE_REF), 32'h0);
    chk(q[7:0], rnd[7:0]);
    chk({sense_reference_second_pair, sense_reference_first_pair},
        rnd[7:0]);
    bus(1'b1, 32'h00000020, 32'hFFFFFFFF);
    bus(1'b0, 32'h00000020, 32'h0);
    chk(q, 32'h0);
    for (int k = 0; k <= 16; k++) begin
      step_k <= 5'(k);
      @(posedge hclk);
      bus(1'b1, 32'(ADDR_STEP_AB), word);
      rnd = lfsr(rnd);
      bus(1'b1, 32'(ADDR_STEP_CD), rnd);
      repeat (2) @(posedge hclk);
      chk(winding_current_code, {rnd[7:4], rnd[14:11],
          4'(16 - k > 15 ? 15 : 16 - k), 4'(k > 15 ? 15 : k)});
    end
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      c = cfgl[i % 4];
      {p, d, e} = rnd[9:0];
      // config written while asleep, so the remap must still be pending
      pins(1'b0);
      bus(1'b1, 32'(ADDR_SETUP), 32'(c));
      bus(1'b0, 32'(ADDR_STATUS), 32'h0);
      chk(q[STAT_REMAP_BIT], 1'b0);
      chk(bridge_switch, 16'h0);
      pins(1'b1);
      bus(1'b0, 32'(ADDR_STATUS), 32'h0);
      chk(q[STAT_REMAP_BIT], c == 3'h5);
      case (c)
        3'h3: x = exp4({e[3:2], {2{p[1]}}}, {d[3:2], {2{p[0]}}});
        3'h4: x = exp4({{2{e[2]}}, {2{p[1]}}}, {{2{d[2]}}, {2{p[0]}}});
        3'h7: x = exp4({4{p[1]}}, {4{p[0]}});
        default: x = exp4(e, d);
      endcase
      chk(bridge_switch, x);
    end
    {e, d, p} = {4'hF, 4'h5, 2'h0};
    pins(1'b1);
    for (int f = 1; f < 3; f++) begin
      {thermal_shutdown_fault, overcurrent_fault} <= 2'(f);
      repeat (3) @(posedge hclk);
      chk(bridge_switch, 16'h0);
      {thermal_shutdown_fault, overcurrent_fault} <= 2'h0;
      repeat (10) @(posedge hclk);
      chk(bridge_switch, 16'h6969);
    end
    // comparator already high before turn-on must wait out dc blanking
    e = 4'hE;
    pins(1'b1);
    sense_trip_raw <= 4'h1;
    e = 4'hF;
    pins(1'b1);
    chk(bridge_switch[0], 4'h9);
    repeat (10) @(posedge hclk);
    chk(bridge_switch[0], 4'h0);
    // stepper bridge a trips after the short window; c, d on pin 2
    {e, d, p} = {4'h4, 4'h2, 2'h0};
    pins(1'b0);
    bus(1'b1, 32'(ADDR_SETUP), 32'h1);
    bus(1'b1, 32'(ADDR_STEP_AB), 32'h00004850);
    pins(1'b1);
    chk(bridge_switch, 16'h6690);
    chk(winding_current_code, 16'h0059);
    bus(1'b1, 32'(ADDR_SETUP), 32'h6);
    repeat (10) @(posedge hclk);
    chk(winding_current_code, 16'h5959);
    bus(1'b1, 32'(ADDR_SETUP), 32'h2);
    repeat (10) @(posedge hclk);
    chk(bridge_switch, 16'h0690);
    sense_trip_raw <= 4'h0;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(bridge_switch, 16'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 32'(ADDR_SETUP), 32'h0);
    chk(q[2:0], 3'h0);
    tally_and_finish();
  end
endmodule // testbench
bind hb_motor_ctrl hb_motor_ctrl_chk #(.DEAD_CYC(DEAD_CYC)) u_chk (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hrdata,
  .hresp, .sleep_control_low, .overcurrent_fault, .thermal_shutdown_fault,
  .bridge_switch);
